// File: hdl/fdc_fmt_dump.v
// track format and register dump command processing of the floppy controller
// assumes host bytes and encoder handshake on sys_clk_in; index pin is asynchronous
// Notes on behaviour
// - dump takes opcode only, returns ten bytes
// - bytes 1-4 give per-drive track low byte
// - bytes 5-6 give specify timing and dma
// - byte 7 sectors-per-track after recent format
// - byte 7 end-of-track after later read/write
// - byte 8 bits 5-0 perpendicular config bits
// - byte 8 bit 7 reports lock flag
// - bytes 9-10 mirror command_a bytes three, four
// - format opcode pattern then five parameters
// - opcode bit 6 picks fm or mfm
// - second byte bit 2 selects side, inverted output
// - size code gives 128 shifted data bytes
// - third parameter sets sectors per track
// - fourth parameter sets gap 3 length
// - data field filled with pattern byte
// - formatting starts after first index pulse
// - second index ends format, raises interrupt
// - id transfer same for dma and pio
// - layout follows index field flag and gdc
// - only first three status bytes meaningful
// - format result is seven bytes
`timescale 1ns/1ps
`default_nettype none
`include "fdc_fmt_dump_defines.vh"

module fdc_fmt_dump (
  input wire sys_clk_in, // 25 MHz clock
  input wire resetn_in, // async reset, active low
  input wire cmd_valid_in, // host command byte present
  input wire [7:0] cmd_data_in, // host command byte
  output reg cmd_ready_out, // command byte accepted when high
  output reg res_valid_out, // result byte available
  output reg [7:0] res_data_out, // result byte
  input wire res_rd_in, // host takes result byte
  input wire id_valid_in, // host id byte present (dma or pio)
  input wire [7:0] id_data_in, // host id byte
  output reg id_ready_out, // id byte accepted when high
  input wire [11:0] present_track_value_d0_in, // drive 0 track
  input wire [11:0] present_track_value_d1_in, // drive 1 track
  input wire [11:0] present_track_value_d2_in, // drive 2 track
  input wire [11:0] present_track_value_d3_in, // drive 3 track
  input wire [3:0] step_rate_in, // stored step rate time
  input wire [3:0] delay_after_in, // stored delay after processing
  input wire [6:0] delay_before_in, // stored delay before processing
  input wire dma_select_in, // stored dma select
  input wire [7:0] end_of_track_sector_in, // last read/write end sector
  input wire rw_done_in, // pulse: read or write executed
  input wire [5:0] per_drive_config_bits_in, // perpendicular byte bits 5-0
  input wire lock_flag_in, // reset protection flag
  input wire implied_seek_enable_in, // command_a byte 3 bit 6
  input wire fifo_disable_in, // command_a byte 3 bit 5
  input wire poll_disable_in, // command_a byte 3 bit 4
  input wire [3:0] fifo_threshold_in, // command_a byte 3 bits 3-0
  input wire [7:0] precomp_start_track_in, // command_a byte 4
  input wire index_addr_field_flag_in, // 1: no index address field
  input wire index_pin_in, // index pulse from drive
  output reg [7:0] wr_data_out, // track byte to encoder
  output reg wr_valid_out, // track byte present
  output reg wr_mark_out, // byte carries missing-clock mark
  input wire wr_ready_in, // encoder takes byte
  output reg write_gate_out, // writing track
  output reg mfm_out, // 1 mfm, 0 fm
  output reg head_side_output_n, // active low side 1 select
  output reg [1:0] logical_drive_select_out, // selected drive
  output reg fmt_irq_out // pulse at format end
);

  localparam ST_IDLE = 3'd0;
  localparam ST_PARAM = 3'd1;
  localparam ST_WAIT_IDX = 3'd2;
  localparam ST_TRACK = 3'd3;
  localparam ST_RES_LOAD = 3'd4;
  localparam ST_RESULT = 3'd5;

  localparam S_GAP4A = 4'd0;
  localparam S_SYNC_I = 4'd1;
  localparam S_IAM = 4'd2;
  localparam S_GAP1 = 4'd3;
  localparam S_SYNC_ID = 4'd4;
  localparam S_IDAM = 4'd5;
  localparam S_ID = 4'd6;
  localparam S_IDCRC = 4'd7;
  localparam S_GAP2 = 4'd8;
  localparam S_SYNC_D = 4'd9;
  localparam S_DAM = 4'd10;
  localparam S_DATA = 4'd11;
  localparam S_DCRC = 4'd12;
  localparam S_GAP3 = 4'd13;
  localparam S_GAP4B = 4'd14;

  reg [2:0] state;
  reg [2:0] param_cnt;
  reg [7:0] opcode;
  reg [7:0] drive_byte;
  reg [7:0] size_code;
  reg [7:0] sectors_per_track;
  reg [7:0] gap3_len;
  reg [7:0] fill_pattern;
  reg last_was_format;
  reg [7:0] res_mem [0:9];
  reg [3:0] res_ptr;
  reg [3:0] res_len;
  reg [3:0] seg;
  reg [15:0] cnt;
  reg [7:0] sec_left;
  reg [15:0] crc;
  reg [7:0] id_buf;
  reg id_have;
  reg idx_meta;
  reg idx_sync;
  reg idx_prev;
  wire idx_edge;
  wire is_mfm;
  wire perp;
  wire free;
  reg [3:0] next_seg;
  reg [7:0] next_byte;
  reg next_mark;
  reg [15:0] next_crc;

  assign idx_edge = idx_sync & ~idx_prev;
  assign is_mfm = opcode[`OPC_MFM_BIT];
  assign perp = |per_drive_config_bits_in[1:0];
  assign free = ~wr_valid_out | wr_ready_in;

  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] r;
    begin
      r = c ^ {d, 8'h00};
      for (i = 0; i < 8; i = i + 1) begin
        r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
      end
      crc_byte = r;
    end
  endfunction

  // data length from size code; gap 3; gap2 by gdc
  function [15:0] seg_len;
    input [3:0] s;
    input mfm;
    input perpendicular;
    input [7:0] g3;
    input [2:0] sz;
    begin
      case (s)
        S_GAP4A: seg_len = mfm ? `GAP4A_MFM : `GAP4A_FM;
        S_SYNC_I, S_SYNC_ID, S_SYNC_D: seg_len = mfm ? `SYNC_MFM : `SYNC_FM;
        S_IAM, S_IDAM, S_DAM: seg_len = mfm ? `MARK_LEN_MFM : `MARK_LEN_FM;
        S_GAP1: seg_len = mfm ? `GAP1_MFM : `GAP1_FM;
        S_ID: seg_len = `ID_LEN;
        S_IDCRC, S_DCRC: seg_len = `CRC_LEN;
        S_GAP2: seg_len = perpendicular ? `GAP2_PERP : (mfm ? `GAP2_MFM : `GAP2_FM);
        S_DATA: seg_len = `DATA_LEN_BASE << sz;
        S_GAP3: seg_len = {8'h00, g3};
        default: seg_len = 16'h0001;
      endcase
    end
  endfunction

  // next segment and byte of the track
  always @* begin
    next_seg = seg + 4'd1;
    next_byte = is_mfm ? `FILL_MFM : `FILL_FM;
    next_mark = 1'b0;
    next_crc = crc;
    case (seg)
      // iso layout drops index sync and mark
      S_GAP4A: next_seg = index_addr_field_flag_in ? S_GAP1 : S_SYNC_I;
      S_GAP1: next_seg = (sectors_per_track == 8'h00) ? S_GAP4B : S_SYNC_ID;
      S_GAP3: next_seg = (sec_left > 8'd1) ? S_SYNC_ID : S_GAP4B;
      S_GAP4B: next_seg = S_GAP4B;
      default: next_seg = seg + 4'd1;
    endcase
    case (seg)
      S_SYNC_I, S_SYNC_ID, S_SYNC_D: next_byte = `SYNC_BYTE;
      S_IAM, S_IDAM, S_DAM: begin
        if (is_mfm && cnt > 16'd1) begin
          next_byte = (seg == S_IAM) ? `PRE_IAM : `PRE_AM;
          next_mark = 1'b1;
        end else begin
          next_byte = (seg == S_IAM) ? `IAM_BYTE : ((seg == S_IDAM) ? `IDAM_BYTE : `DAM_BYTE);
          next_mark = ~is_mfm;
        end
      end
      S_ID: next_byte = id_buf;
      S_DATA: next_byte = fill_pattern;
      S_IDCRC, S_DCRC: next_byte = (cnt == 16'd2) ? crc[15:8] : crc[7:0];
      default: next_byte = is_mfm ? `FILL_MFM : `FILL_FM;
    endcase
    if ((seg == S_IDAM || seg == S_DAM) && cnt == seg_len(seg, is_mfm, perp, gap3_len, size_code[2:0]))
      next_crc = crc_byte(`CRC_INIT, next_byte);
    else if (seg == S_IDAM || seg == S_DAM || seg == S_ID || seg == S_DATA)
      next_crc = crc_byte(crc, next_byte);
  end

  // index pin passes two flops before the edge detector
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      idx_meta <= 1'b0;
      idx_sync <= 1'b0;
      idx_prev <= 1'b0;
    end else begin
      idx_meta <= index_pin_in;
      idx_sync <= idx_meta;
      idx_prev <= idx_sync;
    end
  end

  // format marks byte seven as sector count; set wins over rw clear
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      last_was_format <= 1'b0;
    else if (state == ST_PARAM && cmd_valid_in && cmd_ready_out && param_cnt == 3'd1)
      last_was_format <= 1'b1;
    // later read or write selects end-of-track
    else if (rw_done_in)
      last_was_format <= 1'b0;
  end

  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      param_cnt <= 3'd0;
      opcode <= 8'h00;
      drive_byte <= 8'h00;
      size_code <= 8'h00;
      sectors_per_track <= 8'h00;
      gap3_len <= 8'h00;
      fill_pattern <= 8'h00;
      res_ptr <= 4'd0;
      res_len <= 4'd0;
      seg <= S_GAP4A;
      cnt <= 16'h0000;
      sec_left <= 8'h00;
      crc <= `CRC_INIT;
      id_buf <= 8'h00;
      id_have <= 1'b0;
      cmd_ready_out <= 1'b0;
      res_valid_out <= 1'b0;
      res_data_out <= 8'h00;
      id_ready_out <= 1'b0;
      wr_data_out <= 8'h00;
      wr_valid_out <= 1'b0;
      wr_mark_out <= 1'b0;
      write_gate_out <= 1'b0;
      mfm_out <= 1'b0;
      head_side_output_n <= 1'b1;
      logical_drive_select_out <= 2'b00;
      fmt_irq_out <= 1'b0;
    end else begin
      fmt_irq_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          cmd_ready_out <= 1'b1;
          if (cmd_valid_in && cmd_ready_out) begin
            opcode <= cmd_data_in;
            if (cmd_data_in == `OPC_DUMP) begin
              cmd_ready_out <= 1'b0;
              // low byte of each drive track
              res_mem[0] <= present_track_value_d0_in[7:0];
              res_mem[1] <= present_track_value_d1_in[7:0];
              res_mem[2] <= present_track_value_d2_in[7:0];
              res_mem[3] <= present_track_value_d3_in[7:0];
              res_mem[4] <= {step_rate_in, delay_after_in};
              res_mem[5] <= {delay_before_in, dma_select_in};
              res_mem[6] <= last_was_format ? sectors_per_track : end_of_track_sector_in;
              res_mem[7] <= {lock_flag_in, 1'b0, per_drive_config_bits_in};
              res_mem[8] <= {1'b0, implied_seek_enable_in, fifo_disable_in, poll_disable_in, fifo_threshold_in};
              res_mem[9] <= precomp_start_track_in;
              res_len <= `DUMP_RES_LEN;
              state <= ST_RES_LOAD;
            // format opcode with density bit masked
            end else if ((cmd_data_in & `OPC_FMT_MASK) == `OPC_FMT) begin
              param_cnt <= `FMT_PARAM_COUNT;
              state <= ST_PARAM;
            end
          end
        end
        ST_PARAM: begin
          if (cmd_valid_in && cmd_ready_out) begin
            param_cnt <= param_cnt - 3'd1;
            case (param_cnt)
              3'd5: drive_byte <= cmd_data_in;
              3'd4: size_code <= cmd_data_in;
              3'd3: sectors_per_track <= cmd_data_in;
              3'd2: gap3_len <= cmd_data_in;
              default: fill_pattern <= cmd_data_in;
            endcase
            if (param_cnt == 3'd1) begin
              cmd_ready_out <= 1'b0;
              mfm_out <= opcode[`OPC_MFM_BIT];
              logical_drive_select_out <= drive_byte[`DS_MSB:0];
              // side bit drives the low-active output inverted
              head_side_output_n <= ~drive_byte[`HD_BIT];
              state <= ST_WAIT_IDX;
            end
          end
        end
        ST_WAIT_IDX: begin
          // nothing is written before an index pulse
          if (idx_edge) begin
            write_gate_out <= 1'b1;
            seg <= S_GAP4A;
            cnt <= seg_len(S_GAP4A, is_mfm, perp, gap3_len, size_code[2:0]);
            sec_left <= sectors_per_track;
            state <= ST_TRACK;
          end
        end
        ST_TRACK: begin
          // one id byte taken per handshake, any transfer mode
          if (id_valid_in && id_ready_out) begin
            id_buf <= id_data_in;
            id_have <= 1'b1;
            id_ready_out <= 1'b0;
          end
          if (idx_edge) begin
            // second index ends the track, interrupt pulse
            wr_valid_out <= 1'b0;
            wr_mark_out <= 1'b0;
            write_gate_out <= 1'b0;
            id_ready_out <= 1'b0;
            id_have <= 1'b0;
            fmt_irq_out <= 1'b1;
            res_mem[0] <= {5'b00000, drive_byte[`HD_BIT], drive_byte[`DS_MSB:0]};
            res_mem[1] <= 8'h00;
            res_mem[2] <= 8'h00;
            res_mem[3] <= 8'h00;
            res_mem[4] <= 8'h00;
            res_mem[5] <= 8'h00;
            res_mem[6] <= 8'h00;
            res_len <= `FMT_RES_LEN;
            state <= ST_RES_LOAD;
          end else if (free) begin
            // an id byte not yet supplied stalls the track
            if (seg == S_ID && !id_have) begin
              wr_valid_out <= 1'b0;
            end else begin
              wr_data_out <= next_byte;
              wr_mark_out <= next_mark;
              wr_valid_out <= 1'b1;
              crc <= next_crc;
              if (seg == S_ID)
                id_have <= 1'b0;
              if (seg == S_ID && cnt > 16'd1)
                id_ready_out <= 1'b1;
              if (cnt == 16'd1) begin
                seg <= next_seg;
                cnt <= seg_len(next_seg, is_mfm, perp, gap3_len, size_code[2:0]);
                if (next_seg == S_ID)
                  id_ready_out <= 1'b1;
                if (seg == S_GAP3)
                  sec_left <= sec_left - 8'd1;
              end else if (seg != S_GAP4B) begin
                cnt <= cnt - 16'd1;
              end
            end
          end
        end
        ST_RES_LOAD: begin
          res_ptr <= 4'd0;
          res_data_out <= res_mem[0];
          res_valid_out <= 1'b1;
          state <= ST_RESULT;
        end
        ST_RESULT: begin
          if (res_rd_in && res_valid_out) begin
            if (res_ptr == res_len - 4'd1) begin
              res_valid_out <= 1'b0;
              state <= ST_IDLE;
            end else begin
              res_ptr <= res_ptr + 4'd1;
              res_data_out <= res_mem[res_ptr + 4'd1];
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // fdc_fmt_dump
`default_nettype wire

// File: hdl/fdc_fmt_dump_defines.vh
// constants for the track format and register dump command block
// assumes one 25 MHz clock and byte-wide host and encoder handshakes
`ifndef FDC_FMT_DUMP_DEFINES_VH
`define FDC_FMT_DUMP_DEFINES_VH

// opcodes
`define OPC_DUMP 8'h0e
`define OPC_FMT_MASK 8'hbf
`define OPC_FMT 8'h0d
`define OPC_MFM_BIT 6
`define FMT_PARAM_COUNT 3'd5

// result lengths
`define DUMP_RES_LEN 4'd10
`define FMT_RES_LEN 4'd7

// second format byte fields
`define HD_BIT 2
`define DS_MSB 1

// data field length for size code zero
`define DATA_LEN_BASE 16'h0080

// gap and sync lengths in bytes
`define GAP4A_MFM 16'd80
`define GAP4A_FM 16'd40
`define SYNC_MFM 16'd12
`define SYNC_FM 16'd6
`define GAP1_MFM 16'd50
`define GAP1_FM 16'd26
`define GAP2_MFM 16'd22
`define GAP2_FM 16'd11
`define GAP2_PERP 16'd41
`define MARK_LEN_MFM 16'd4
`define MARK_LEN_FM 16'd1
`define ID_LEN 16'd4
`define CRC_LEN 16'd2

// byte values written to the track
`define FILL_MFM 8'h4e
`define FILL_FM 8'hff
`define SYNC_BYTE 8'h00
`define PRE_IAM 8'hc2
`define PRE_AM 8'ha1
`define IAM_BYTE 8'hfc
`define IDAM_BYTE 8'hfe
`define DAM_BYTE 8'hfb

// crc-ccitt
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h1021

`endif

// File: bench/fdc_host_id_model.sv
// host side model that hands per-sector id bytes to the format block
// assumes the id handshake of fdc_fmt_dump on one clock
`timescale 1ns/1ps
`default_nettype none
module fdc_host_id_model (
  input wire logic clk_in, // clock
  input wire logic resetn_in, // async reset, active low
  input wire logic slow_in, // idle a cycle after each byte
  input wire logic [7:0] head_in, // head byte of each id
  input wire logic [7:0] size_in, // size code of each id
  input wire logic id_ready_in, // block takes the byte
  output logic id_valid_out, // byte offered
  output logic [7:0] id_data_out // id byte
);
  logic [1:0] pos;
  logic [7:0] sector;
  logic [7:0] cur;
  always_comb begin
    case (pos)
      2'd0: cur = 8'h01;
      2'd1: cur = head_in;
      2'd2: cur = sector;
      default: cur = size_in;
    endcase
  end
  // not offered: show the inverse so a stale byte cannot pass
  assign id_data_out = id_valid_out ? cur : ~cur;
  // same handshake paced fast or slow
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pos <= 2'd0;
      sector <= 8'h01;
      id_valid_out <= 1'b0;
    end else if (!id_valid_out) begin
      id_valid_out <= 1'b1;
    end else if (id_ready_in) begin
      pos <= pos + 2'd1;
      if (pos == 2'd3) sector <= sector + 8'h01;
      id_valid_out <= !slow_in;
    end
  end
endmodule // fdc_host_id_model
`default_nettype wire

// File: bench/fdc_fmt_dump_asserts.sv
// port checker for the format and register dump block
// bound to every fdc_fmt_dump instance
`timescale 1ns/1ps
`default_nettype none
module fdc_fmt_dump_asserts (
  input wire logic sys_clk_in, // clock
  input wire logic resetn_in, // async reset, active low
  input wire logic cmd_valid_in, // command byte present
  input wire logic [7:0] cmd_data_in, // command byte
  input wire logic cmd_ready_out, // command byte taken
  input wire logic res_valid_out, // result present
  input wire logic [7:0] res_data_out, // result byte
  input wire logic res_rd_in, // result popped
  input wire logic wr_valid_out, // track byte present
  input wire logic [7:0] wr_data_out, // track byte
  input wire logic wr_ready_in, // encoder ready
  input wire logic write_gate_out, // writing track
  input wire logic fmt_irq_out // format end pulse
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  logic [2:0] par;
  wire take = cmd_valid_in && cmd_ready_out;
  // parameters still owed; an opcode is only a byte taken with none owed
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) par <= 3'h0;
    else if (take) par <= (par != 3'h0) ? par - 3'h1 : ((cmd_data_in & 8'hbf) == 8'h0d) ? 3'h5 : 3'h0;
  end
  wire opc = take && par == 3'h0;
  property p_dump_ans;
    opc && cmd_data_in == 8'h0e |=> !cmd_ready_out ##1 res_valid_out;
  endproperty
  a_dump_ans: assert property (p_dump_ans) else $error("dump gave no result");
  property p_bad_opc;
    opc && cmd_data_in != 8'h0e && (cmd_data_in & 8'hbf) != 8'h0d |=> (cmd_ready_out && !res_valid_out) [*3];
  endproperty
  a_bad_opc: assert property (p_bad_opc) else $error("foreign opcode not dropped");
  property p_fmt_last;
    take && par == 3'h1 |=> !cmd_ready_out;
  endproperty
  a_fmt_last: assert property (p_fmt_last) else $error("ready after last format byte");
  property p_res_hold;
    res_valid_out && !res_rd_in |=> res_valid_out && $stable(res_data_out);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("result byte lost");
  property p_res_busy;
    res_valid_out |-> !cmd_ready_out;
  endproperty
  a_res_busy: assert property (p_res_busy) else $error("ready during result");
  property p_irq_pulse;
    fmt_irq_out |=> !fmt_irq_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("end pulse too long");
  property p_irq_res;
    fmt_irq_out |-> ##[1:3] res_valid_out;
  endproperty
  a_irq_res: assert property (p_irq_res) else $error("no result after format end");
  property p_wr_hold;
    wr_valid_out && !wr_ready_in && write_gate_out |=> !wr_valid_out || $stable(wr_data_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("track byte changed unsent");
  property p_gate_busy;
    write_gate_out |-> !cmd_ready_out && !res_valid_out;
  endproperty
  a_gate_busy: assert property (p_gate_busy) else $error("busy rules broken while writing");
endmodule // fdc_fmt_dump_asserts
bind fdc_fmt_dump fdc_fmt_dump_asserts u_chk (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
  .cmd_valid_in(cmd_valid_in), .cmd_data_in(cmd_data_in), .cmd_ready_out(cmd_ready_out),
  .res_valid_out(res_valid_out), .res_data_out(res_data_out), .res_rd_in(res_rd_in),
  .wr_valid_out(wr_valid_out), .wr_data_out(wr_data_out), .wr_ready_in(wr_ready_in),
  .write_gate_out(write_gate_out), .fmt_irq_out(fmt_irq_out));
`default_nettype wire

// File: bench/fdc_fmt_dump_tb_top.sv
// self-checking bench for the format and register dump block
// assumes the host id model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module fdc_fmt_dump_tb_top;
  logic clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, res_rd = 1'b0, rw_done = 1'b0, idx = 1'b0;
  logic wr_ready = 1'b1, stall = 1'b0, index_addr_field_flag = 1'b0;
  logic [7:0] cmd_data = 8'h00, id_head = 8'h00, id_size = 8'h00;
  logic cmd_ready, res_valid, id_ready, id_valid, wr_valid, wr_mark, wr_gate, mfm, hsel_n, irq;
  logic [7:0] res_data, id_data, wr_data;
  logic [1:0] drv;
  logic [7:0] res_q[$];
  int error_cnt = 0, tests_run = 0, fill_cnt = 0, fill_bad = 0, dleft = 0, ileft = 0, iam_cnt = 0, irq_cnt = 0;
  logic prev_mark = 1'b0;
  logic [2:0] cur_sz = 3'h0;
  logic [7:0] id_sec = 8'h01;
  // stored controller settings, varied between dumps
  logic [11:0] trk0 = 12'h312, trk1 = 12'h1a5, trk2 = 12'hf7c, trk3 = 12'h003;
  logic [3:0] step_rate = 4'h9, delay_after = 4'h3, fifo_thr = 4'h7;
  logic [6:0] delay_before = 7'h45;
  logic dma_sel = 1'b1, lock_flag = 1'b1, seek_en = 1'b1, fifo_dis = 1'b0, poll_dis = 1'b1;
  logic [7:0] track_end = 8'h24, precomp = 8'h3c;
  logic [5:0] pd_cfg = 6'h2a;
  always #20 clk = ~clk;
  fdc_fmt_dump dut (.sys_clk_in(clk), .resetn_in(rstn), .cmd_valid_in(cmd_valid), .cmd_data_in(cmd_data),
    .cmd_ready_out(cmd_ready), .res_valid_out(res_valid), .res_data_out(res_data), .res_rd_in(res_rd),
    .id_valid_in(id_valid), .id_data_in(id_data), .id_ready_out(id_ready),
    .present_track_value_d0_in(trk0), .present_track_value_d1_in(trk1),
    .present_track_value_d2_in(trk2), .present_track_value_d3_in(trk3),
    .step_rate_in(step_rate), .delay_after_in(delay_after),
    .delay_before_in(delay_before), .dma_select_in(dma_sel),
    .end_of_track_sector_in(track_end), .rw_done_in(rw_done), .per_drive_config_bits_in(pd_cfg),
    .lock_flag_in(lock_flag), .implied_seek_enable_in(seek_en),
    .fifo_disable_in(fifo_dis), .poll_disable_in(poll_dis),
    .fifo_threshold_in(fifo_thr), .precomp_start_track_in(precomp), .index_addr_field_flag_in(index_addr_field_flag),
    .index_pin_in(idx), .wr_data_out(wr_data), .wr_valid_out(wr_valid), .wr_mark_out(wr_mark),
    .wr_ready_in(wr_ready), .write_gate_out(wr_gate), .mfm_out(mfm), .head_side_output_n(hsel_n),
    .logical_drive_select_out(drv), .fmt_irq_out(irq));
  fdc_host_id_model host (.clk_in(clk), .resetn_in(rstn), .slow_in(stall), .head_in(id_head),
    .size_in(id_size), .id_ready_in(id_ready), .id_valid_out(id_valid), .id_data_out(id_data));
  // encoder stalls every other cycle when asked
  always @(posedge clk) wr_ready <= stall ? ~wr_ready : 1'b1;
  // walk the encoder stream: only bytes inside data fields count, so crc bytes cannot pose as fill
  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      prev_mark <= wr_mark;
      if (dleft > 0) begin
        dleft <= dleft - 1;
        if (wr_data === 8'h6d) fill_cnt <= fill_cnt + 1;
        else fill_bad <= fill_bad + 1;
      end else if (ileft > 0) begin
        ileft <= ileft - 1;
        chk("id byte", ileft == 4 ? 8'h01 : ileft == 3 ? id_head : ileft == 2 ? id_sec : id_size, wr_data);
        if (ileft == 1) id_sec <= id_sec + 8'h01;
      end else if (wr_mark === 1'b1 || prev_mark === 1'b1) begin
        if (wr_data === 8'hfb) dleft <= 128 << cur_sz;
        if (wr_data === 8'hfe) ileft <= 4;
        if (wr_data === 8'hfc) iam_cnt <= iam_cnt + 1;
      end
    end
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_data <= b;
    @(posedge clk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
  endtask
  task automatic get_res(input int cnt);
    int w;
    w = 0;
    res_q = {};
    while (res_q.size() < cnt && w < 5000) begin
      w++;
      @(posedge clk);
      if (res_valid === 1'b1) begin
        res_q.push_back(res_data);
        res_rd <= 1'b1;
        @(posedge clk);
        res_rd <= 1'b0;
      end
    end
    chk("result count", cnt, res_q.size());
  endtask
  task automatic pulse_index;
    idx <= 1'b1;
    repeat (4) @(posedge clk);
    idx <= 1'b0;
    @(posedge clk);
  endtask
  task automatic dump_check(input logic [7:0] b7);
    logic [7:0] e[10];
    e = '{trk0[7:0], trk1[7:0], trk2[7:0], trk3[7:0], {step_rate, delay_after}, {delay_before, dma_sel}, b7,
      {lock_flag, 1'b0, pd_cfg}, {1'b0, seek_en, fifo_dis, poll_dis, fifo_thr}, precomp};
    send(8'h0e);
    cmd_valid <= 1'b0;
    get_res(10);
    for (int i = 0; i < 10; i++) chk($sformatf("dump byte %0d", i + 1), e[i], res_q[i]);
  endtask
  task automatic bad_opcodes;
    logic [7:0] ops[3];
    ops = '{8'h00, 8'h8d, 8'h4e};
    foreach (ops[i]) begin
      send(ops[i]);
      cmd_valid <= 1'b0;
      repeat (4) @(posedge clk);
      chk("ready after foreign opcode", 16'h1, cmd_ready);
      chk("result after foreign opcode", 16'h0, res_valid);
    end
  endtask
  task automatic rw_pulse;
    rw_done <= 1'b1;
    @(posedge clk);
    rw_done <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fmt(input logic [7:0] opc, input logic [7:0] b2, input logic [2:0] sz, input logic [7:0] spt);
    int base, bad0, iam0, irq0, w;
    base = fill_cnt;
    bad0 = fill_bad;
    iam0 = iam_cnt;
    irq0 = irq_cnt;
    cur_sz <= sz;
    id_head <= {7'h0, b2[2]};
    id_size <= {5'h0, sz};
    send(opc);
    send(b2);
    send({5'h0, sz});
    send(spt);
    send(8'h10);
    send(8'h6d);
    cmd_valid <= 1'b0;
    repeat (20) @(posedge clk);
    chk("gate before index", 16'h0, wr_gate);
    pulse_index();
    repeat (10) @(posedge clk);
    chk("gate after index", 16'h1, wr_gate);
    chk("encoding", opc[6], mfm);
    chk("drive select", b2[1:0], drv);
    chk("side select pin", {15'h0, ~b2[2]}, hsel_n);
    w = 0;
    while (fill_cnt - base < spt * (128 << sz) && w < 30000) begin
      w++;
      @(posedge clk);
    end
    repeat (200) @(posedge clk);
    pulse_index();
    // the one-cycle pulse is gone before pulse_index returns, so it is counted
    repeat (4) @(posedge clk);
    chk("end pulse", 16'h1, irq_cnt - irq0);
    chk("fill bytes", spt * (128 << sz), fill_cnt - base);
    chk("fill pattern", 16'h0, fill_bad - bad0);
    chk("index mark", {15'h0, ~index_addr_field_flag}, iam_cnt - iam0);
    get_res(7);
    chk("status 0", {13'h0, b2[2:0]}, res_q[0]);
    chk("status 1", 16'h0, res_q[1]);
    chk("status 2", 16'h0, res_q[2]);
    chk("gate after end", 16'h0, wr_gate);
  endtask
  initial begin
    #2000000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    bad_opcodes();
    rw_pulse();
    dump_check(track_end);
    fmt(8'h4d, 8'h05, 3'h0, 8'h02);
    dump_check(8'h02);
    stall <= 1'b1;
    index_addr_field_flag <= 1'b1;
    fmt(8'h0d, 8'hfb, 3'h1, 8'h01);
    trk2 <= 12'h0c6;
    delay_before <= 7'h3a;
    lock_flag <= 1'b0;
    pd_cfg <= 6'h15;
    fifo_dis <= 1'b1;
    track_end <= 8'h12;
    rw_pulse();
    dump_check(track_end);
    end_sim();
  end
endmodule // fdc_fmt_dump_tb_top
`default_nettype wire
